/* core/gps_top.sv */
// Our own choices: the APB slave port and the address map.
module gps_top import gps_pkg::*; (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hard_reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads
  input wire logic [NPIN-1:0] pad_di,
  output logic [NPIN-1:0] pad_do,
  output logic [NPIN-1:0] pad_oe_n,
  output logic [NPIN-1:0] pad_pu,
  output logic [NPIN-1:0] pad_ds,
  // Peripheral functions
  input wire logic [NPER-1:0][NPIN-1:0] per_do,
  input wire logic [NPER-1:0][NPIN-1:0] per_oe,
  output logic [NPIN-1:0] per_di,
  // Fault sources and RC oscillator
  input wire logic flt_supply,
  input wire logic flt_osc_wdog,
  input wire logic flt_clk_cmp,
  input wire logic flt_trig_router,
  input wire logic rc_osc,
  // Requests
  output logic [NCH-1:0] pin_irq_channels,
  output logic safe_active
);

  gps_st_t q, d;
  gps_sf_t sq, sd;
  logic acc, wr, cap;
  logic [NPIN-1:0] src, o, oe, rx;
  logic [NPIN-1:0] ds, lvl, safe_on;
  logic [NPIN-1:0][NPER-1:0] pdo, poe;
  logic [NCH-1:0][31:0] pins, lset, lclr;
  logic [1:0] hp;
  logic [4:0] pidx;
  logic [2:0] ch;
  logic in_ch;
  logic mux_hit;
  logic [1:0] mux_idx;
  logic [3:0] gap;
  logic tick;

  // ****************************************
  // APB handshake
  // ****************************************
  // One wait state: pready rises in the second access cycle, so read data
  // is registered from a stable address and outputs stay flop-driven.
  assign acc = psel & penable;
  assign cap = acc & ~q.rdy;
  assign wr = acc & pwrite & q.rdy;
  assign ch = paddr[7:5];
  assign in_ch = (paddr[11:8] == A_CH_PAGE) && (ch < 3'(NCH));
  // Only the four aligned mux words match, so a near miss cannot alias
  // onto one of them and is refused like any other unmapped word
  assign mux_hit = (paddr[1:0] == 2'h0) && (paddr[11:2] >= A_MUX0[11:2]) &&
                   (paddr[11:2] <= A_MUX0[11:2] + 10'h3);
  assign mux_idx = 2'(paddr[3:2] - A_MUX0[3:2]);

  // ****************************************
  // Pin slices
  // ****************************************
  // Delayed pins join at the second step only
  assign safe_on = q.s_en & ((sq.st == SF_STEP2) ? {NPIN{1'b1}} :
                   (sq.st == SF_STEP1) ? ~q.s_dly : {NPIN{1'b0}});

  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    for (genvar p = 0; p < NPER; p++) begin : g_per
      assign pdo[g][p] = per_do[p][g];
      assign poe[g][p] = per_oe[p][g];
    end
    gps_pin pin_u (
      .fn(q.mux[g/8][(g%8)*4 +: 3]),
      .dout(q.dout[g]),
      .dir(q.dir[g]),
      .inen(q.inen[g]),
      .drive(q.drive[g]),
      .per_do(pdo[g]),
      .per_oe(poe[g]),
      .safe_on(safe_on[g]),
      .s_val(q.s_val[g]),
      .s_hiz(q.s_hiz[g]),
      .sync2(q.sync2[g]),
      .prev(q.prev[g]),
      .pol(q.pol[g]),
      .edg(q.edg[g]),
      .both(q.both[g]),
      .swev(q.swev[g]),
      .imask(q.imask[g]),
      .o(o[g]),
      .oe(oe[g]),
      .rx(rx[g]),
      .ds(ds[g]),
      .lvl(lvl[g]),
      .src(src[g])
    );
  end

  always_comb begin
    d = q;
    pins = '0;
    lset = '0;
    lclr = '0;
    hp = 2'h0;
    pidx = 5'h0;
    d.rdy = cap;
    // The error flag stands with ready for one cycle only
    d.err = 1'b0;
    d.swev = '0;
    d.sync1 = pad_di;
    d.sync2 = q.sync1;

    // ****************************************
    // Register writes
    // ****************************************
    if (wr) begin
      if (in_ch) begin
        case (paddr[4:0])
          C_ASN: begin
            for (int b = 0; b < NHP; b++) begin
              d.asn[ch][b] = pwdata[b*8 +: 3];
            end
          end
          C_MSET: d.cmask[ch] = q.cmask[ch] | pwdata;
          C_MCLR: d.cmask[ch] = q.cmask[ch] & ~pwdata;
          C_LCLR: lclr[ch] = pwdata;
          default: d.err = 1'b0;
        endcase
      end else begin
        case (paddr)
          A_DATA: d.dout = pwdata;
          A_DATA_SET: d.dout = q.dout | pwdata;
          A_DATA_CLR: d.dout = q.dout & ~pwdata;
          A_DIR: d.dir = pwdata;
          A_DIR_SET: d.dir = q.dir | pwdata;
          A_DIR_CLR: d.dir = q.dir & ~pwdata;
          A_INEN: d.inen = pwdata;
          A_PULL: d.pull = pwdata;
          A_IMSK: d.imask = pwdata;
          A_IMSK_SET: d.imask = q.imask | pwdata;
          A_IMSK_CLR: d.imask = q.imask & ~pwdata;
          A_EDGE: d.edg = pwdata;
          A_BOTH: d.both = pwdata;
          A_POL: d.pol = pwdata;
          A_SWIRQ: d.swev = pwdata;
          A_DRIVE: d.drive = pwdata;
          A_SEN: d.s_en = pwdata;
          A_SVAL: d.s_val = pwdata;
          A_SHIZ: d.s_hiz = pwdata;
          A_SDLY: d.s_dly = pwdata;
          A_SCFG: d.s_cfg = pwdata;
          default: begin
            if (mux_hit) begin
              d.mux[mux_idx] = pwdata;
            end
          end
        endcase
      end
    end

    // ****************************************
    // Pin datapath
    // ****************************************
    d.pad_do = o;
    d.pad_oe_n = ~oe;
    d.pad_pu = q.pull;
    d.pad_ds = ds;
    d.prev = lvl;
    d.rx = rx;

    // ****************************************
    // Interrupt channels
    // ****************************************
    for (int c = 0; c < NCH; c++) begin
      for (int b = 0; b < NHP; b++) begin
        hp = q.asn[c][b][1:0];
        for (int k = 0; k < 8; k++) begin
          pidx = {hp, 3'(k)};
          if (q.asn[c][b][2]) begin
            lset[c][b*8+k] = src[pidx];
            pins[c][b*8+k] = rx[pidx];
          end
        end
      end
      // A new event beats a clear in the same cycle
      d.latch[c] = (q.latch[c] & ~lclr[c]) | lset[c];
      d.irq[c] = |(q.latch[c] & q.cmask[c]);
    end

    // ****************************************
    // Register reads
    // ****************************************
    if (cap) begin
      d.err = 1'b0;
      d.rdata = '0;
      if (in_ch) begin
        case (paddr[4:0])
          C_ASN: begin
            for (int b = 0; b < NHP; b++) begin
              d.rdata[b*8 +: 3] = q.asn[ch][b];
            end
          end
          C_MSET, C_MCLR: d.rdata = q.cmask[ch];
          C_LAT, C_LCLR: d.rdata = q.latch[ch];
          C_PINS: d.rdata = pins[ch];
          default: d.err = 1'b1;
        endcase
      end else begin
        case (paddr)
          A_DATA, A_DATA_SET, A_DATA_CLR: d.rdata = q.dout;
          A_DIR, A_DIR_SET, A_DIR_CLR: d.rdata = q.dir;
          A_INEN: d.rdata = q.inen;
          A_PULL: d.rdata = q.pull;
          A_IMSK, A_IMSK_SET, A_IMSK_CLR: d.rdata = q.imask;
          A_EDGE: d.rdata = q.edg;
          A_BOTH: d.rdata = q.both;
          A_POL: d.rdata = q.pol;
          A_SWIRQ: d.rdata = '0;
          A_INPUT: d.rdata = q.rx;
          A_DRIVE: d.rdata = q.drive;
          A_SEN: d.rdata = q.s_en;
          A_SVAL: d.rdata = q.s_val;
          A_SHIZ: d.rdata = q.s_hiz;
          A_SDLY: d.rdata = q.s_dly;
          A_SCFG: d.rdata = q.s_cfg;
          A_SSTAT: d.rdata = {28'h0, sq.cnt[1:0], sq.st};
          default: begin
            if (mux_hit) begin
              d.rdata = q.mux[mux_idx];
            end else begin
              d.err = 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.s_cfg <= RST_SCFG;
      q.pad_oe_n <= '1;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Safe-state sequencer
  // ****************************************
  // Each rising RC edge is one step of about a microsecond. Limitation:
  // the edge is sampled on pclk, so pclk must outrun the RC oscillator.
  assign tick = sq.r2 & ~sq.r3;
  assign gap = (q.s_cfg[CFG_GAP_LSB +: 4] < GAP_MIN_US) ? GAP_MIN_US :
               q.s_cfg[CFG_GAP_LSB +: 4];

  always_comb begin
    sd = sq;
    sd.f1 = {flt_trig_router, flt_clk_cmp, flt_osc_wdog, flt_supply};
    sd.f2 = sq.f1;
    sd.r1 = rc_osc;
    sd.r2 = sq.r1;
    sd.r3 = sq.r2;
    case (sq.st)
      SF_IDLE: begin
        sd.cnt = 4'h0;
        if (|(sq.f2 & q.s_cfg[3:0])) begin
          sd.st = SF_STEP1;
        end
      end
      SF_STEP1: begin
        if (tick) begin
          sd.cnt = sq.cnt + 4'h1;
          if (sq.cnt + 4'h1 >= gap) begin
            sd.st = SF_STEP2;
          end
        end
      end
      SF_STEP2: sd.st = SF_STEP2;
      default: sd.st = SF_IDLE;
    endcase
    sd.act = (sd.st != SF_IDLE);
  end

  // Only the hard reset pin ends a taken fault; presetn leaves it alone
  always_ff @(posedge pclk or negedge hard_reset_n) begin
    if (!hard_reset_n) begin
      sq <= '0;
    end else begin
      sq <= sd;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign pad_do = q.pad_do;
  assign pad_oe_n = q.pad_oe_n;
  assign pad_pu = q.pad_pu;
  assign pad_ds = q.pad_ds;
  assign per_di = q.rx;
  assign pin_irq_channels = q.irq;
  assign safe_active = sq.act;

endmodule

module gps_pin import gps_pkg::*; (
  // Configuration
  input wire logic [2:0] fn,
  input wire logic dout,
  input wire logic dir,
  input wire logic inen,
  input wire logic drive,
  // Peripheral side
  input wire logic [NPER-1:0] per_do,
  input wire logic [NPER-1:0] per_oe,
  // Safe state
  input wire logic safe_on,
  input wire logic s_val,
  input wire logic s_hiz,
  // Detection
  input wire logic sync2,
  input wire logic prev,
  input wire logic pol,
  input wire logic edg,
  input wire logic both,
  input wire logic swev,
  input wire logic imask,
  // Results
  output logic o,
  output logic oe,
  output logic rx,
  output logic ds,
  output logic lvl,
  output logic src
);

  always_comb begin
    o = 1'b0;
    oe = 1'b0;
    if (fn == FN_GPIO) begin
      o = dout;
      oe = dir;
    end else if (fn <= 3'(NPER)) begin
      o = per_do[fn - 3'h1];
      oe = per_oe[fn - 3'h1];
    end
    // Unselected pins keep the muxed function through a fault
    if (safe_on) begin
      o = s_val;
      oe = ~s_hiz;
    end
    rx = (oe && inen) ? o : sync2;
    ds = drive && (fn == FN_PWM);
    // Detection uses the received level, except that pins with dir set take the software event
    lvl = rx ^ pol;
    if (dir) begin
      src = swev;
    end else if (!edg) begin
      src = lvl;
    end else if (both) begin
      src = lvl ^ prev;
    end else begin
      src = lvl & ~prev;
    end
    src = src & imask;
  end

endmodule

/* core/gps_pkg.sv */
package gps_pkg;
  localparam int NPIN = 32;
  localparam int NCH = 6;
  localparam int NHP = 4;
  localparam int NPER = 5;
  localparam logic [2:0] FN_GPIO = 3'h0;
  localparam logic [2:0] FN_PWM = 3'h1;
  localparam logic [11:0] A_DATA = 12'h000;
  localparam logic [11:0] A_DATA_SET = 12'h004;
  localparam logic [11:0] A_DATA_CLR = 12'h008;
  localparam logic [11:0] A_DIR = 12'h00c;
  localparam logic [11:0] A_DIR_SET = 12'h010;
  localparam logic [11:0] A_DIR_CLR = 12'h014;
  localparam logic [11:0] A_INEN = 12'h018;
  localparam logic [11:0] A_PULL = 12'h01c;
  localparam logic [11:0] A_IMSK = 12'h020;
  localparam logic [11:0] A_IMSK_SET = 12'h024;
  localparam logic [11:0] A_IMSK_CLR = 12'h028;
  localparam logic [11:0] A_EDGE = 12'h02c;
  localparam logic [11:0] A_BOTH = 12'h030;
  localparam logic [11:0] A_POL = 12'h034;
  localparam logic [11:0] A_SWIRQ = 12'h038;
  localparam logic [11:0] A_INPUT = 12'h03c;
  localparam logic [11:0] A_DRIVE = 12'h040;
  localparam logic [11:0] A_MUX0 = 12'h044;
  localparam logic [11:0] A_SEN = 12'h060;
  localparam logic [11:0] A_SVAL = 12'h064;
  localparam logic [11:0] A_SHIZ = 12'h068;
  localparam logic [11:0] A_SDLY = 12'h06c;
  localparam logic [11:0] A_SCFG = 12'h070;
  localparam logic [11:0] A_SSTAT = 12'h074;
  localparam logic [3:0] A_CH_PAGE = 4'h1;
  localparam logic [4:0] C_ASN = 5'h00;
  localparam logic [4:0] C_MSET = 5'h04;
  localparam logic [4:0] C_MCLR = 5'h08;
  localparam logic [4:0] C_LAT = 5'h0c;
  localparam logic [4:0] C_LCLR = 5'h10;
  localparam logic [4:0] C_PINS = 5'h14;
  localparam int CFG_GAP_LSB = 8;
  localparam logic [31:0] RST_SCFG = 32'h0000_0100;
  localparam logic [3:0] GAP_MIN_US = 4'h1;
  typedef enum logic [1:0] {
    SF_IDLE = 2'b00,
    SF_STEP1 = 2'b01,
    SF_STEP2 = 2'b10
  } gps_sf_st_t;
  typedef struct packed {
    gps_sf_st_t st;
    logic [3:0] cnt;
    logic [3:0] f1, f2;
    logic r1, r2, r3;
    logic act;
  } gps_sf_t;
  typedef struct packed {
    logic [31:0] dout, dir, inen, pull, imask, edg, both, pol, drive;
    logic [3:0][31:0] mux;
    logic [31:0] s_en, s_val, s_hiz, s_dly, s_cfg;
    logic [NCH-1:0][NHP-1:0][2:0] asn;
    logic [NCH-1:0][31:0] cmask, latch;
    logic [31:0] sync1, sync2, rx, prev, swev;
    logic [31:0] pad_do, pad_oe_n, pad_pu, pad_ds;
    logic [NCH-1:0] irq;
    logic rdy, err;
    logic [31:0] rdata;
  } gps_st_t;
endpackage

/* bench/gps_chk_sva.sv */
module gps_chk import gps_pkg::*; (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hard_reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Pins, faults, requests
  input wire logic [NPIN-1:0] pad_oe_n,
  input wire logic flt_supply,
  input wire logic flt_osc_wdog,
  input wire logic flt_clk_cmp,
  input wire logic flt_trig_router,
  input wire logic [NCH-1:0] pin_irq_channels,
  input wire logic safe_active
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic calm;
  assign calm = !(flt_supply || flt_osc_wdog || flt_clk_cmp || flt_trig_router);
  // ***************
  // Checks
  // ***************
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait_ready;
    psel && penable && !pready ##1 psel && penable && pready;
  endsequence
  AST_ONE_WAIT: assert property (s_setup |=> s_wait_ready)
    else $error("reply not after one wait state");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_REQ: assert property (pready |-> psel && penable)
    else $error("ready without a request");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNMAP: assert property (pready && paddr == 12'hffc |-> pslverr)
    else $error("unmapped word accepted");
  AST_MAPPED: assert property (pready && paddr == A_DATA |-> !pslverr)
    else $error("data word refused");
  // Only the hard reset pin may drop a taken fault, the bus reset must not
  AST_HOLD: assert property (@(posedge pclk) disable iff (!hard_reset_n)
    safe_active |=> safe_active) else $error("safe state left early");
  AST_CAUSE: assert property ((!safe_active && calm) [*5] |=> !safe_active)
    else $error("safe state without a fault");
  AST_RST_OUT: assert property ($rose(presetn) |-> &pad_oe_n && pin_irq_channels == '0)
    else $error("outputs not idle after reset");
endmodule

/* bench/gps_pad_model.sv */
module gps_pad_model (
  // Pad side
  input wire logic pclk,
  input wire logic [31:0] pad_do,
  input wire logic [31:0] pad_oe_n,
  input wire logic [31:0] pad_pu,
  // External circuitry
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  output logic [31:0] pad_di
);
  timeunit 1ns;
  timeprecision 100ps;
  logic flip = 1'b0;
  // A floating line wanders, so no stale level can be leaned on
  always @(posedge pclk) flip <= ~flip;
  assign pad_di = (~pad_oe_n & pad_do) | (pad_oe_n & ext_en & ext_val)
    | (pad_oe_n & ~ext_en & (pad_pu | {32{flip}}));
endmodule

/* bench/port_pin_irq_safe_state_test.sv */
module port_pin_irq_safe_state_test import gps_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, hrst_n = 0, rc_osc = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, pad_di, pad_do, pad_oe_n, pad_pu, pad_ds, per_di;
  logic [31:0] ext_en = '1, ext_val = 0, dm, rm, ev, r;
  logic [NPER-1:0][NPIN-1:0] per_do = 0, per_oe = 0;
  logic [3:0] flt = 0;
  logic [5:0] irq;
  logic safe, e;
  int err_total = 0, compares = 0, n;
  always #5 pclk = ~pclk;
  always #500.3 rc_osc = ~rc_osc;
  gps_top dut_u (.pclk(pclk), .presetn(presetn), .hard_reset_n(hrst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_di(pad_di), .pad_do(pad_do),
    .pad_oe_n(pad_oe_n), .pad_pu(pad_pu), .pad_ds(pad_ds), .per_do(per_do),
    .per_oe(per_oe), .per_di(per_di), .flt_supply(flt[0]), .flt_osc_wdog(flt[1]),
    .flt_clk_cmp(flt[2]), .flt_trig_router(flt[3]), .rc_osc(rc_osc),
    .pin_irq_channels(irq), .safe_active(safe));
  gps_pad_model pad_u (.pclk(pclk), .pad_do(pad_do), .pad_oe_n(pad_oe_n), .pad_pu(pad_pu),
    .ext_en(ext_en), .ext_val(ext_val), .pad_di(pad_di));
  task tally_and_finish;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task wt(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // Master holds everything until ready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    wt(1);
    penable <= 1;
    n = 0;
    do begin
      wt(1);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // Idle edge, so the next call never re-drives a strobe in this step
    wt(1);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(r, x);
  endtask
  function automatic logic [11:0] ca(input logic [4:0] o);
    return {A_CH_PAGE, 3'h0, o};
  endfunction
  initial begin
    #200us;
    err_total++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h4022dbc6));
    wt(10);
    presetn <= 1;
    hrst_n <= 1;
    wt(1);
    // ***************
    // Registers and pins
    // ***************
    rd(A_SCFG, RST_SCFG);
    apb(0, 12'hffc, 0);
    chk(e, 1);
    dm = $urandom;
    wr(A_DATA, dm);
    ev = $urandom;
    wr(A_DATA_SET, ev);
    dm |= ev;
    ev = $urandom;
    wr(A_DATA_CLR, ev);
    dm &= ~ev;
    rd(A_DATA, dm);
    rm = $urandom;
    ev = $urandom;
    ext_val <= ev;
    wr(A_DIR, rm);
    wr(A_INEN, '1);
    wt(4);
    chk(pad_oe_n, ~rm);
    chk(pad_do & rm, dm & rm);
    rd(A_INPUT, (rm & dm) | (~rm & ev));
    ext_en <= 0;
    wr(A_PULL, '1);
    wt(4);
    chk(pad_pu, '1);
    rd(A_INPUT, (rm & dm) | ~rm);
    ext_en <= '1;
    per_do <= {$urandom, $urandom, $urandom, $urandom, $urandom};
    per_oe[0] <= 32'h1;
    wr(A_MUX0, 32'h1);
    wr(A_DRIVE, 32'h1);
    wt(3);
    chk(pad_ds[0], 1);
    chk({pad_oe_n[0], pad_do[0]}, {1'b0, per_do[0][0]});
    wr(A_MUX0, 0);
    wt(2);
    chk(pad_ds[0], 0);
    // ***************
    // Pin interrupts
    // ***************
    ext_val <= 0;
    wr(A_DIR, 32'h400);
    wr(A_EDGE, '1);
    wr(A_IMSK, '1);
    wr(ca(C_ASN), 32'h5);
    wr(ca(C_MSET), 32'hff);
    wt(4);
    wr(ca(C_LCLR), '1);
    ext_val <= 32'h100;
    wt(5);
    rd(ca(C_LAT), 1);
    chk(irq, 6'h1);
    wr(ca(C_LCLR), 1);
    ext_val <= 0;
    wt(5);
    rd(ca(C_LAT), 0);
    wr(ca(C_MCLR), 1);
    ext_val <= 32'h100;
    wr(A_SWIRQ, 32'h400);
    wt(5);
    rd(ca(C_LAT), 5);
    wr(ca(C_LCLR), 4);
    wt(3);
    rd(ca(C_LAT), 1);
    chk(irq, 0);
    rd(ca(C_MSET), 32'hfe);
    wr(A_BOTH, '1);
    wr(ca(C_LCLR), '1);
    ext_val <= 0;
    wt(5);
    rd(ca(C_LAT), 1);
    rd(ca(C_PINS), {29'h0, dm[10], 2'h0});
    // ***************
    // Safe state, each fault source in turn
    // ***************
    for (int k = 0; k < 4; k++) begin
      wr(A_DIR, 7);
      wr(A_DATA, 0);
      wr(A_SEN, 3);
      wr(A_SVAL, 1);
      wr(A_SHIZ, 2);
      wr(A_SDLY, 2);
      wr(A_SCFG, 32'h300 | (1 << k));
      flt[k] <= 1;
      n = 0;
      while (safe !== 1'b1 && n < 20) begin
        wt(1);
        n++;
      end
      flt <= 0;
      chk(safe, 1);
      wt(3);
      chk({pad_oe_n[2:0], pad_do[2:0]}, 6'h01);
      wt(450);
      chk({pad_oe_n[2:0], pad_do[2:0]}, 6'h11);
      presetn <= 0;
      wt(2);
      presetn <= 1;
      wt(1);
      chk(safe, 1);
      hrst_n <= 0;
      wt(2);
      hrst_n <= 1;
      wt(1);
      chk(safe, 0);
    end
    tally_and_finish;
  end
endmodule
bind gps_top gps_chk chk_u (.pclk(pclk), .presetn(presetn), .hard_reset_n(hard_reset_n),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .pad_oe_n(pad_oe_n), .flt_supply(flt_supply), .flt_osc_wdog(flt_osc_wdog),
  .flt_clk_cmp(flt_clk_cmp), .flt_trig_router(flt_trig_router),
  .pin_irq_channels(pin_irq_channels), .safe_active(safe_active));
